// *** verilog/ccb_pkg.sv ***
// Shared constants of the clock crossing bridge
`default_nettype none
package ccb_pkg;
  localparam int SADDR_W   = 32;                      // Upstream byte address width
  localparam int OFFS_W    = 12;                      // Downstream offset width (bridge window)
  localparam int DATA_W    = 32;                      // Data width both sides
  localparam int BE_W      = DATA_W / 8;              // Byte enables
  localparam int BURST_W   = 4;                       // Burst count width
  localparam int MAX_BURST = 1 << (BURST_W - 1);      // Longest burst in words
  localparam int CMD_AW    = 3;                       // Command FIFO depth is 2**CMD_AW
  localparam int RSP_AW    = 4;                       // Default response FIFO depth 2**RSP_AW
  // Command entry layout, data in the low bits
  localparam int DATA_LSB  = 0;
  localparam int BE_LSB    = DATA_LSB + DATA_W;
  localparam int BC_LSB    = BE_LSB + BE_W;
  localparam int ADDR_LSB  = BC_LSB + BURST_W;
  localparam int WR_BIT    = ADDR_LSB + OFFS_W;
  localparam int CMD_W     = WR_BIT + 1;
  // Reset values
  localparam logic [BURST_W-1:0] BC_ONE   = 4'h1;     // Burst of one word
  localparam logic               WAIT_RST = 1'b1;     // Stall upstream during reset
endpackage
`default_nettype wire

// *** verilog/ccb_async_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
// Dual clock FIFO with gray pointers and show-ahead read data
module ccb_async_fifo #(
  parameter int W  = 8,
  parameter int AW = 3
) (
  input  wire logic         wr_clk,
  input  wire logic         wr_rst_n,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_full,
  output logic              wr_full_nxt,
  input  wire logic         rd_clk,
  input  wire logic         rd_rst_n,
  input  wire logic         rd_en,
  output logic [W-1:0]      rd_data,
  output logic              rd_empty
);
  localparam int DEPTH = 1 << AW;

  logic [W-1:0] mem [DEPTH];                // Storage, written in write domain only
  logic [AW:0]  wbin_r, wbin_nxt;           // Write pointer, binary
  logic [AW:0]  wgray_r, wgray_nxt;         // Write pointer, gray
  logic [AW:0]  rbin_r, rbin_nxt;           // Read pointer, binary
  logic [AW:0]  rgray_r, rgray_nxt;         // Read pointer, gray
  logic [AW:0]  rg_s1_r, rg_s2_r;           // Read pointer into write domain
  logic [AW:0]  wg_s1_r, wg_s2_r;           // Write pointer into read domain
  logic         full_r;
  logic         empty_r, empty_nxt;

  // Write side next state; full tracks the push just made
  always_comb begin
    wbin_nxt    = wbin_r + (AW+1)'(wr_en & ~full_r);
    wgray_nxt   = wbin_nxt ^ (wbin_nxt >> 1);
    wr_full_nxt = (wgray_nxt == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
  end

  // Write side registers; only gray crosses, one bit changes per step
  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin_r  <= '0;
      wgray_r <= '0;
      full_r  <= 1'b0;
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end else begin
      wbin_r  <= wbin_nxt;
      wgray_r <= wgray_nxt;
      full_r  <= wr_full_nxt;
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
    end
  end

  // Storage write, no reset needed on data
  always_ff @(posedge wr_clk) begin
    if (wr_en && !full_r) begin
      mem[wbin_r[AW-1:0]] <= wr_data;
    end
  end

  // Read side next state
  always_comb begin
    rbin_nxt  = rbin_r + (AW+1)'(rd_en & ~empty_r);
    rgray_nxt = rbin_nxt ^ (rbin_nxt >> 1);
    empty_nxt = (rgray_nxt == wg_s2_r);
  end

  // Read side registers
  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin_r  <= '0;
      rgray_r <= '0;
      empty_r <= 1'b1;
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end else begin
      rbin_r  <= rbin_nxt;
      rgray_r <= rgray_nxt;
      empty_r <= empty_nxt;
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
    end
  end

  assign wr_full  = full_r;
  assign rd_empty = empty_r;
  assign rd_data  = mem[rbin_r[AW-1:0]];
endmodule // ccb_async_fifo
`default_nettype wire

// *** verilog/ccb_bridge.sv ***
// Behaviour
// - Separate command and response dual clock FIFOs
// - Accepted upstream transfers reissued on downstream port
// - Buffer lets upstream post several reads
// - Burst width w gives 2**(w-1) words
// - Missing or zero burst count means one
// - Response FIFO depth is a parameter
// - Outstanding reads capped by response FIFO depth
// - Pipelined, variable latency, burst capable ports
// - Downstream address is offset bits only
// - Buffering adds cycles of read latency
`timescale 1ns/1ps
`default_nettype none
module ccb_bridge #(
  parameter int RSP_AW = ccb_pkg::RSP_AW              // Response depth is 2**RSP_AW, at least MAX_BURST (8)
) (
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic [ccb_pkg::SADDR_W-1:0]  s_address,
  input  wire logic                         s_read,
  input  wire logic                         s_write,
  input  wire logic [ccb_pkg::DATA_W-1:0]   s_writedata,
  input  wire logic [ccb_pkg::BE_W-1:0]     s_byteenable,
  input  wire logic [ccb_pkg::BURST_W-1:0]  s_burstcount,
  output logic                              s_waitrequest,
  output logic [ccb_pkg::DATA_W-1:0]        s_readdata,
  output logic                              s_readdatavalid,
  input  wire logic                         m_clk,
  input  wire logic                         m_rst_n,
  output logic [ccb_pkg::OFFS_W-1:0]        m_address,
  output logic                              m_read,
  output logic                              m_write,
  output logic [ccb_pkg::DATA_W-1:0]        m_writedata,
  output logic [ccb_pkg::BE_W-1:0]          m_byteenable,
  output logic [ccb_pkg::BURST_W-1:0]       m_burstcount,
  input  wire logic                         m_waitrequest,
  input  wire logic [ccb_pkg::DATA_W-1:0]   m_readdata,
  input  wire logic                         m_readdatavalid
);
  localparam int CW = RSP_AW + 1;                     // Credit counter width
  localparam logic [CW-1:0] CRED_FULL = CW'(1 << RSP_AW);
  localparam logic [CW-1:0] CRED_MIN  = CW'(ccb_pkg::MAX_BURST);

  // Master side states
  typedef enum logic [1:0] {
    MS_IDLE  = 2'b01,                                 // Nothing on the downstream port
    MS_ISSUE = 2'b10                                  // Transfer held until taken
  } ccb_ms_e;

  // Reset synchronisers, one per domain
  logic                          s_rs1_r, s_rs2_r;    // Core side reset release
  logic                          m_rs1_r, m_rs2_r;    // Master side reset release
  // Core side state
  logic                          wait_r, wait_nxt;    // Registered stall to upstream
  logic [CW-1:0]                 cred_r, cred_nxt;    // Free response slots
  logic [ccb_pkg::DATA_W-1:0]    rdata_r, rdata_nxt;
  logic                          rvld_r, rvld_nxt;
  logic                          accept;              // Upstream transfer taken
  logic [ccb_pkg::BURST_W-1:0]   bc_eff;              // Burst count, zero read as one
  logic [ccb_pkg::CMD_W-1:0]     cmd_in;
  logic                          cmd_full_nxt;
  logic                          cmd_full;
  // Master side state
  ccb_ms_e                       ms_r, ms_nxt;
  logic [ccb_pkg::OFFS_W-1:0]    maddr_r, maddr_nxt;
  logic                          mrd_r, mrd_nxt;
  logic                          mwr_r, mwr_nxt;
  logic [ccb_pkg::DATA_W-1:0]    mwd_r, mwd_nxt;
  logic [ccb_pkg::BE_W-1:0]      mbe_r, mbe_nxt;
  logic [ccb_pkg::BURST_W-1:0]   mbc_r, mbc_nxt;
  logic                          cmd_pop;
  logic                          cmd_empty;
  logic [ccb_pkg::CMD_W-1:0]     cmd_out;
  // Response path
  logic [ccb_pkg::DATA_W-1:0]    rsp_out;
  logic                          rsp_empty;

  // Core side reset: asynchronous assert, synchronous release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_rs1_r <= 1'b0;
      s_rs2_r <= 1'b0;
    end else begin
      s_rs1_r <= 1'b1;
      s_rs2_r <= s_rs1_r;
    end
  end

  // Master side reset, same scheme on its own clock
  always_ff @(posedge m_clk or negedge m_rst_n) begin
    if (!m_rst_n) begin
      m_rs1_r <= 1'b0;
      m_rs2_r <= 1'b0;
    end else begin
      m_rs1_r <= 1'b1;
      m_rs2_r <= m_rs1_r;
    end
  end

  // Command queue, core clock to master clock
  ccb_async_fifo #(
    .W  (ccb_pkg::CMD_W),
    .AW (ccb_pkg::CMD_AW)
  ) u_cmd_fifo (
    .wr_clk      (core_clk),
    .wr_rst_n    (s_rs2_r),
    .wr_en       (accept),
    .wr_data     (cmd_in),
    .wr_full     (cmd_full),
    .wr_full_nxt (cmd_full_nxt),
    .rd_clk      (m_clk),
    .rd_rst_n    (m_rs2_r),
    .rd_en       (cmd_pop),
    .rd_data     (cmd_out),
    .rd_empty    (cmd_empty)
  );

  // Read data queue, master clock back to core clock
  ccb_async_fifo #(
    .W  (ccb_pkg::DATA_W),
    .AW (RSP_AW)
  ) u_rsp_fifo (
    .wr_clk      (m_clk),
    .wr_rst_n    (m_rs2_r),
    .wr_en       (m_readdatavalid),
    .wr_data     (m_readdata),
    .wr_full     (),
    .wr_full_nxt (),
    .rd_clk      (core_clk),
    .rd_rst_n    (s_rs2_r),
    .rd_en       (~rsp_empty),
    .rd_data     (rsp_out),
    .rd_empty    (rsp_empty)
  );

  // Core side: take requests, count response slots, return read data
  always_comb begin
    // Full flag is a second guard; the registered stall already covers it
    accept   = (s_read | s_write) & ~wait_r & ~cmd_full;
    // Zero burst count is taken as a single word
    bc_eff   = (s_burstcount == '0) ? ccb_pkg::BC_ONE : s_burstcount;
    // Offset bits only go downstream; base decode is upstream's job
    cmd_in   = {s_write, s_address[ccb_pkg::OFFS_W-1:0], bc_eff,
                s_byteenable, s_writedata};
    cred_nxt = cred_r;
    if (accept && !s_write) begin
      cred_nxt = cred_nxt - CW'(bc_eff);              // Reserve room for every beat
    end
    if (!rsp_empty) begin
      cred_nxt = cred_nxt + CW'(1'b1);                // Slot freed as data leaves
    end
    // Stall keeps a full worst-case burst in hand, so no read can overflow
    wait_nxt  = cmd_full_nxt | (cred_nxt < CRED_MIN);
    rvld_nxt  = ~rsp_empty;                           // Two sync stages, the empty flag flop, then this flop
    rdata_nxt = rvld_nxt ? rsp_out : rdata_r;
  end

  // Core side registers
  always_ff @(posedge core_clk or negedge s_rs2_r) begin
    if (!s_rs2_r) begin
      wait_r  <= ccb_pkg::WAIT_RST;
      cred_r  <= CRED_FULL;
      rdata_r <= '0;
      rvld_r  <= 1'b0;
    end else begin
      wait_r  <= wait_nxt;
      cred_r  <= cred_nxt;
      rdata_r <= rdata_nxt;
      rvld_r  <= rvld_nxt;
    end
  end

  // Master side: replay each queued command until the target takes it
  always_comb begin
    ms_nxt    = ms_r;
    maddr_nxt = maddr_r;
    mrd_nxt   = mrd_r;
    mwr_nxt   = mwr_r;
    mwd_nxt   = mwd_r;
    mbe_nxt   = mbe_r;
    mbc_nxt   = mbc_r;
    cmd_pop   = 1'b0;
    unique case (ms_r)
      MS_IDLE: begin
        cmd_pop = ~cmd_empty;                         // Start on first queued entry
      end
      MS_ISSUE: begin
        // Taken when stall is low; chain the next entry with no gap
        cmd_pop = ~m_waitrequest & ~cmd_empty;
        if (!m_waitrequest && cmd_empty) begin
          ms_nxt  = MS_IDLE;
          mrd_nxt = 1'b0;
          mwr_nxt = 1'b0;
        end
      end
    endcase
    if (cmd_pop) begin
      ms_nxt    = MS_ISSUE;
      mwr_nxt   = cmd_out[ccb_pkg::WR_BIT];
      mrd_nxt   = ~cmd_out[ccb_pkg::WR_BIT];
      maddr_nxt = cmd_out[ccb_pkg::ADDR_LSB +: ccb_pkg::OFFS_W];
      mbc_nxt   = cmd_out[ccb_pkg::BC_LSB +: ccb_pkg::BURST_W];
      mbe_nxt   = cmd_out[ccb_pkg::BE_LSB +: ccb_pkg::BE_W];
      mwd_nxt   = cmd_out[ccb_pkg::DATA_LSB +: ccb_pkg::DATA_W];
    end
  end

  // Master side registers
  always_ff @(posedge m_clk or negedge m_rs2_r) begin
    if (!m_rs2_r) begin
      ms_r    <= MS_IDLE;
      maddr_r <= '0;
      mrd_r   <= 1'b0;
      mwr_r   <= 1'b0;
      mwd_r   <= '0;
      mbe_r   <= '0;
      mbc_r   <= ccb_pkg::BC_ONE;
    end else begin
      ms_r    <= ms_nxt;
      maddr_r <= maddr_nxt;
      mrd_r   <= mrd_nxt;
      mwr_r   <= mwr_nxt;
      mwd_r   <= mwd_nxt;
      mbe_r   <= mbe_nxt;
      mbc_r   <= mbc_nxt;
    end
  end

  assign s_waitrequest   = wait_r;
  assign s_readdata      = rdata_r;
  assign s_readdatavalid = rvld_r;
  assign m_address       = maddr_r;
  assign m_read          = mrd_r;
  assign m_write         = mwr_r;
  assign m_writedata     = mwd_r;
  assign m_byteenable    = mbe_r;
  assign m_burstcount    = mbc_r;
endmodule // ccb_bridge
`default_nettype wire

// *** bench/ccb_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// Watches both bridge ports; two clock domains
module ccb_checker #(
  parameter int RSP_AW = ccb_pkg::RSP_AW // Response slots 2**RSP_AW
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        s_read,
  input  wire logic [ccb_pkg::BURST_W-1:0] s_burstcount,
  input  wire logic                        s_waitrequest,
  input  wire logic                        s_readdatavalid,
  input  wire logic                        m_clk,
  input  wire logic                        m_rst_n,
  input  wire logic [ccb_pkg::OFFS_W-1:0]  m_address,
  input  wire logic                        m_read,
  input  wire logic                        m_write,
  input  wire logic [ccb_pkg::DATA_W-1:0]  m_writedata,
  input  wire logic [ccb_pkg::BURST_W-1:0] m_burstcount,
  input  wire logic                        m_waitrequest,
  input  wire logic                        m_readdatavalid
);
  localparam int DEPTH = 1 << RSP_AW;
  localparam int LAG   = 2;  // Slots freed at pop, before the valid is seen
  logic [7:0] up_r, up_nxt;  // Words owed upstream
  logic [7:0] dn_r, dn_nxt;  // Words owed by the target
  function automatic logic [7:0] words(logic [3:0] b);
    return (b == 4'h0) ? 8'h01 : {4'h0, b};
  endfunction
  // Count reserved words against returned words
  always_comb begin
    up_nxt = up_r - {7'h00, s_readdatavalid};
    dn_nxt = dn_r - {7'h00, m_readdatavalid};
    if (s_read && !s_waitrequest) up_nxt = up_nxt + words(s_burstcount);
    if (m_read && !m_waitrequest) dn_nxt = dn_nxt + words(m_burstcount);
  end
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) up_r <= 8'h00;
    else up_r <= up_nxt;
  always_ff @(posedge m_clk or negedge m_rst_n)
    if (!m_rst_n) dn_r <= 8'h00;
    else dn_r <= dn_nxt;
  property p_rd_hold;
    @(posedge m_clk) disable iff (!m_rst_n) m_read && m_waitrequest |=> m_read && $stable(m_address);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("stalled read not held");
  property p_wr_hold;
    @(posedge m_clk) disable iff (!m_rst_n) m_write && m_waitrequest |=> m_write && $stable(m_writedata);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("stalled write not held");
  property p_burst_max;
    @(posedge m_clk) disable iff (!m_rst_n) m_read || m_write |-> m_burstcount != 4'h0 && m_burstcount <= 4'h8;
  endproperty
  a_burst_max: assert property (p_burst_max) else $error("bad burst count");
  property p_dn_cap;
    @(posedge m_clk) disable iff (!m_rst_n) m_read |-> dn_r <= 8'(DEPTH);
  endproperty
  a_dn_cap: assert property (p_dn_cap) else $error("too many reads pending");
  property p_up_credit;
    @(posedge core_clk) disable iff (!rst_n) s_read && !s_waitrequest |-> up_r <= 8'(DEPTH - 8 + LAG);
  endproperty
  a_up_credit: assert property (p_up_credit) else $error("read taken without room");
  property p_rdv_owed;
    @(posedge core_clk) disable iff (!rst_n) s_readdatavalid |-> up_r != 8'h00;
  endproperty
  a_rdv_owed: assert property (p_rdv_owed) else $error("unrequested read word");
  property p_s_rst;
    @(posedge core_clk) disable iff (!rst_n) $rose(rst_n) |-> s_waitrequest [*2];
  endproperty
  a_s_rst: assert property (p_s_rst) else $error("stall dropped too early");
  property p_m_rst;
    @(posedge m_clk) disable iff (!m_rst_n) $rose(m_rst_n) |-> (!m_read && !m_write) [*2];
  endproperty
  a_m_rst: assert property (p_m_rst) else $error("request right after reset");
endmodule // ccb_checker
`default_nettype wire

// *** bench/ccb_target_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Downstream memory target; random stall and latency when slow
module ccb_target_model (
  input  wire logic                        m_clk,
  input  wire logic                        slow,
  input  wire logic [ccb_pkg::OFFS_W-1:0]  m_address,
  input  wire logic                        m_read,
  input  wire logic                        m_write,
  input  wire logic [ccb_pkg::DATA_W-1:0]  m_writedata,
  input  wire logic [ccb_pkg::BE_W-1:0]    m_byteenable,
  input  wire logic [ccb_pkg::BURST_W-1:0] m_burstcount,
  output logic                             m_waitrequest,
  output logic [ccb_pkg::DATA_W-1:0]       m_readdata,
  output logic                             m_readdatavalid
);
  logic [ccb_pkg::DATA_W-1:0] mem [1024];  // Word store
  logic [ccb_pkg::DATA_W-1:0] rq [$];      // Words still to return
  initial begin
    m_waitrequest = 1'b0;
    m_readdatavalid = 1'b0;
    m_readdata = 32'h0000_0000;
  end
  // Take, store, return in order
  always @(posedge m_clk) begin
    if ((m_read || m_write) && !m_waitrequest) begin
      for (int b = 0; b < ccb_pkg::BE_W; b++)
        if (m_write && m_byteenable[b]) mem[m_address[11:2]][8*b+:8] = m_writedata[8*b+:8];
      for (int i = 0; i < ((m_burstcount == 4'h0) ? 1 : int'(m_burstcount)); i++)
        if (m_read) rq.push_back(mem[m_address[11:2] + 10'(i)]);
    end
    m_waitrequest <= slow && ($urandom_range(1) == 1);
    if (rq.size() > 0 && !(slow && $urandom_range(2) == 0)) begin
      m_readdatavalid <= 1'b1;
      m_readdata <= rq.pop_front();
    end else begin
      m_readdatavalid <= 1'b0;
      m_readdata <= ~m_readdata;  // No stale word left on the bus
    end
  end
endmodule // ccb_target_model
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 0, rst_n = 0, m_clk = 0, m_rst_n = 0, slow = 0;
  logic s_read = 0, s_write = 0;
  logic [31:0] s_address = 0, s_writedata = 0;
  logic [3:0] s_byteenable = 4'hF, s_burstcount = 4'h1;
  wire logic s_waitrequest, s_readdatavalid, m_read, m_write, m_waitrequest, m_readdatavalid;
  wire logic [31:0] s_readdata, m_writedata, m_readdata;
  wire logic [11:0] m_address;
  wire logic [3:0] m_byteenable, m_burstcount;
  int n_mismatch = 0, n_checks = 0;
  logic [31:0] shadow [1024];  // Expected target contents
  logic [31:0] exp_q [$];      // Expected read words, in order
  always #20 core_clk = ~core_clk;
  always #13.5 m_clk = ~m_clk;  // Unrelated downstream clock
  ccb_bridge #(.RSP_AW(4)) i_ccb_bridge (.*);
  ccb_target_model i_ccb_target_model (.*);
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One request, held until taken; random upper address bits
  task automatic req(logic wr, logic [11:0] offs, logic [3:0] bc, logic [31:0] d, logic [3:0] be);
    @(negedge core_clk);
    s_address = {20'($urandom), offs};
    {s_write, s_read, s_writedata, s_burstcount, s_byteenable} = {wr, !wr, d, bc, be};
    for (int b = 0; b < 4; b++)
      if (wr && be[b]) shadow[offs[11:2]][8*b+:8] = d[8*b+:8];
    for (int k = 0; k < ((bc == 4'h0) ? 1 : int'(bc)); k++)
      if (!wr) exp_q.push_back(shadow[offs[11:2] + 10'(k)]);
    @(posedge core_clk iff !s_waitrequest);
  endtask
  task automatic drain(string name);
    int k;
    @(negedge core_clk);
    {s_read, s_write} = 2'b00;
    for (k = 0; k < 4000 && exp_q.size() != 0; k++) @(posedge core_clk);
    check("words_left", 32'(exp_q.size()), 0);
    $display("%s done", name);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Compare each returned word with the oldest note, mid-cycle where the pulse has settled
  always @(negedge core_clk)
    if (s_readdatavalid === 1'b1) begin
      if (exp_q.size() == 0) check("extra_word", 1, 0);
      else check("s_readdata", s_readdata, exp_q.pop_front());
    end
  initial begin
    void'($urandom(81339));
    repeat (12) @(posedge core_clk);
    check("wait_in_reset", s_waitrequest, 1);
    check("m_burst_in_reset", m_burstcount, ccb_pkg::BC_ONE);
    @(negedge core_clk);
    {rst_n, m_rst_n} = 2'b11;
    // Fill, then byte lane writes; count 0 stands for one
    for (int i = 0; i < 1024; i++) req(1, 12'(i * 4), 4'(i % 2), $urandom, 4'hF);
    for (int i = 0; i < 16; i++) req(1, 12'($urandom) & 12'hFFC, 4'h1, $urandom, 4'($urandom));
    drain("write");
    // Posted singles, then every burst length
    for (int i = 0; i < 40; i++) req(0, 12'($urandom) & 12'hFFC, 4'h1, 0, 4'hF);
    for (int b = 0; b <= 8; b++) req(0, 12'($urandom) & 12'hFFC, 4'(b), 0, 4'hF);
    drain("read");
    // Stalling, slow target with deep posting
    slow = 1;
    for (int i = 0; i < 24; i++) req(0, 12'($urandom) & 12'hFFC, 4'h8, 0, 4'hF);
    drain("slow");
    slow = 0;
    complete_run;
  end
  // Hang guard
  initial begin
    #1_000_000;  // About 25,000 core cycles, several times a clean run
    n_mismatch++;
    complete_run;
  end
endmodule // testbench
bind ccb_bridge ccb_checker #(.RSP_AW(RSP_AW)) i_ccb_checker (.*);
`default_nettype wire
